/* hdl/pgia_top.sv */
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pgia_top #(
   parameter int GATE_CYC     = pgia_pkg::GATE_CYC,
   parameter int RISE_DLY_CYC = pgia_pkg::RISE_DLY_CYC
) (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire pgia_pkg::pgia_mon_s mon_i,
   input  wire pgia_pkg::pgia_otp_s otp_i,
   input  wire logic               supply_uvlo,
   input  wire logic               reset_event,
   output logic                    host_irq_n,
   output logic                    power_good_out_a,
   output logic                    power_good_out_a_oe,
   output logic                    power_good_out_b,
   output logic                    power_good_out_b_oe
);
   localparam int NSRC = pgia_pkg::NSRC;
   localparam int FW   = pgia_pkg::FLAG_W;

   // Refuse timing counts that the counters cannot hold
   if (GATE_CYC < 1 || GATE_CYC >= (1 << pgia_pkg::CNT_W) ||
       RISE_DLY_CYC < 1 || RISE_DLY_CYC >= (1 << pgia_pkg::CNT_W)) begin : g_bad_timing
      $error("pgia_top: timing count out of counter range");
   end

   // ------------------------------------------------------------
   // Registers and shared state
   // ------------------------------------------------------------
   logic [FW-1:0]   flag_r;
   logic [FW-1:0]   pend_r;
   logic [31:0]     mask_r;
   logic [8:0]      ctrl_r;
   logic [10:0]     pgcfg_r [2];
   logic [1:0]      mode_r;
   logic            otp_load_r;
   logic            uvlo_d_r;
   logic [NSRC-1:0] valid_d_r;
   logic            sync_d_r;
   logic            clkdet_d_r;
   logic [1:0]      pg_good_r;
   logic [NSRC-1:0] valid;
   logic [NSRC-1:0] eff;
   logic [NSRC-1:0] rise_ev;
   logic [NSRC-1:0] fall_ev;
   logic [FW-1:0]   set_v;
   logic [FW-1:0]   pset_v;
   logic [FW-1:0]   clr_v;
   logic [31:0]     wmask;
   logic            wr_req;
   logic            soft_rst;
   logic            sync_ev;
   logic            rreg_ev;

   assign soft_rst = supply_uvlo | reset_event;
   assign wr_req   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o; // Lands on the acked edge
   assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // ------------------------------------------------------------
   // Validity, effective enables and events per source
   // ------------------------------------------------------------
   // Voltage sources judge undervoltage, plus overvoltage when window on
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_src
         if (gi == pgia_pkg::SRC_TWARN) begin : g_warn
            assign valid[gi] = ~mon_i.twarn;
            assign eff[gi]   = ctrl_r[gi];
         end else begin : g_volt
            assign valid[gi] = mon_i.uv_ok[gi] &
                               (mon_i.ov_ok[gi] | ~ctrl_r[pgia_pkg::CTL_OVCHK]);
            if (gi < pgia_pkg::NCONV) begin : g_conv
               assign eff[gi] = ctrl_r[gi] & mon_i.conv_on[gi];
            end else begin : g_in
               assign eff[gi] = ctrl_r[gi];
            end
         end
         assign rise_ev[gi] = eff[gi] & valid[gi] & ~valid_d_r[gi];
         assign fall_ev[gi] = eff[gi] & ~valid[gi] & valid_d_r[gi];
      end
   endgenerate

   // Previous validity, seeded as good so enabling gives no false edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         valid_d_r  <= '1;
         sync_d_r   <= 1'b0;
         clkdet_d_r <= 1'b0;
         uvlo_d_r   <= 1'b0;
      end else begin
         valid_d_r  <= valid | ~eff;
         sync_d_r   <= mon_i.sync_present;
         clkdet_d_r <= ctrl_r[pgia_pkg::CTL_CLKDET];
         uvlo_d_r   <= supply_uvlo;
      end
   end

   // Sync clock change, or detector switched on with no clock
   assign sync_ev = ctrl_r[pgia_pkg::CTL_CLKDET] &
                    ((mon_i.sync_present ^ sync_d_r) |
                     (~clkdet_d_r & ~mon_i.sync_present));
   assign rreg_ev = (uvlo_d_r & ~supply_uvlo) | reset_event;

   // ------------------------------------------------------------
   // Flag set, pending set and clear vectors
   // ------------------------------------------------------------
   always_comb begin
      set_v  = '0;
      pset_v = '0;
      set_v[NSRC-1:0]  = rise_ev | fall_ev;
      pset_v[NSRC-1:0] = (rise_ev & ~mask_r[NSRC-1:0]) |
                         (fall_ev & ~mask_r[pgia_pkg::MSK_FALL +: NSRC]);
      set_v[pgia_pkg::FLG_BUCKG]  = set_v[pgia_pkg::SRC_BUCKA] | set_v[pgia_pkg::SRC_BUCKB];
      set_v[pgia_pkg::FLG_BOOSTG] = set_v[pgia_pkg::SRC_BOOST];
      set_v[pgia_pkg::FLG_DIAGG]  = set_v[pgia_pkg::SRC_SUPPLY] | set_v[pgia_pkg::SRC_RAILA] |
                                    set_v[pgia_pkg::SRC_RAILB];
      set_v[pgia_pkg::FLG_SYNC]   = sync_ev;
      set_v[pgia_pkg::FLG_MEAS]   = mon_i.meas_done;
      set_v[pgia_pkg::FLG_RREG]   = rreg_ev;
      pset_v[pgia_pkg::FLG_SYNC]  = sync_ev & ~mask_r[pgia_pkg::MSK_SYNC];
      pset_v[pgia_pkg::FLG_MEAS]  = mon_i.meas_done & ~mask_r[pgia_pkg::MSK_MEAS];
      pset_v[pgia_pkg::FLG_RREG]  = rreg_ev & ~mask_r[pgia_pkg::MSK_RREG];
      clr_v = '0;
      if (wr_req && wb_adr_i == pgia_pkg::OFS_FLAG) begin
         clr_v = wb_dat_i[FW-1:0] & wmask[FW-1:0];
      end
   end

   // Sticky flags, set wins over a same-cycle clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_r <= pgia_pkg::FLAG_RST;
      end else if (supply_uvlo) begin
         flag_r <= '0;
      end else begin
         flag_r <= (flag_r & ~clr_v) | set_v;
      end
   end

   // Pending interrupt sources, cleared together with their flag
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_r <= '0;
      end else if (supply_uvlo) begin
         pend_r <= '0;
      end else begin
         pend_r <= (pend_r & ~clr_v) | pset_v;
      end
   end

   // Level-type sources contribute while their flag stands unmasked
   logic irq_any;
   assign irq_any = |pend_r |
                    (flag_r[pgia_pkg::FLG_RREG] & ~mask_r[pgia_pkg::MSK_RREG]) |
                    (flag_r[pgia_pkg::FLG_SYNC] & ~mask_r[pgia_pkg::MSK_SYNC]) |
                    (flag_r[pgia_pkg::FLG_MEAS] & ~mask_r[pgia_pkg::MSK_MEAS]);

   // Interrupt pin, low while anything is pending
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         host_irq_n <= 1'b1;
      end else begin
         host_irq_n <= ~irq_any | supply_uvlo;
      end
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   // Mask, control and pin configuration; defaults on any reset event
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_r     <= pgia_pkg::MASK_RST;
         ctrl_r     <= pgia_pkg::CTRL_RST;
         pgcfg_r[0] <= pgia_pkg::PGCFG_RST;
         pgcfg_r[1] <= pgia_pkg::PGCFG_RST;
      end else if (soft_rst) begin
         mask_r     <= pgia_pkg::MASK_RST;
         ctrl_r     <= pgia_pkg::CTRL_RST;
         pgcfg_r[0] <= pgia_pkg::PGCFG_RST;
         pgcfg_r[1] <= pgia_pkg::PGCFG_RST;
      end else if (otp_load_r) begin
         pgcfg_r[0][pgia_pkg::PG_POL] <= otp_i.polarity[0];
         pgcfg_r[1][pgia_pkg::PG_POL] <= otp_i.polarity[1];
      end else if (wr_req) begin
         case (wb_adr_i)
            pgia_pkg::OFS_MASK: mask_r <= (mask_r & ~wmask) | (wb_dat_i & wmask);
            pgia_pkg::OFS_CTRL: ctrl_r <= (ctrl_r & ~wmask[8:0]) | (wb_dat_i[8:0] & wmask[8:0]);
            pgia_pkg::OFS_PGCFG: begin
               pgcfg_r[0] <= (pgcfg_r[0] & ~wmask[10:0]) | (wb_dat_i[10:0] & wmask[10:0]);
               pgcfg_r[1] <= (pgcfg_r[1] & ~wmask[26:16]) | (wb_dat_i[26:16] & wmask[26:16]);
            end
            default: ;
         endcase
      end
   end

   // One-time config load after power-up and every reset event
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         otp_load_r <= 1'b1;
         mode_r     <= 2'h0;
      end else begin
         otp_load_r <= soft_rst;
         if (otp_load_r) begin
            mode_r <= otp_i.gated_mode;
         end
      end
   end

   // ------------------------------------------------------------
   // Gated-mode blanking after each converter enable
   // ------------------------------------------------------------
   logic [pgia_pkg::NCONV-1:0] blank;
   generate
      for (gi = 0; gi < pgia_pkg::NCONV; gi++) begin : g_blank
         logic [pgia_pkg::CNT_W-1:0] bcnt_r;
         logic                       on_d_r;
         // Window counter restarted on the converter enable edge
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               bcnt_r <= '0;
               on_d_r <= 1'b0;
            end else begin
               on_d_r <= mon_i.conv_on[gi];
               if (mon_i.conv_on[gi] && !on_d_r) begin
                  bcnt_r <= pgia_pkg::CNT_W'(GATE_CYC);
               end else if (bcnt_r != '0) begin
                  bcnt_r <= bcnt_r - 1'b1;
               end
            end
         end
         assign blank[gi] = (bcnt_r != '0) | (mon_i.conv_on[gi] & ~on_d_r);
      end
   endgenerate

   // ------------------------------------------------------------
   // Power-good pins
   // ------------------------------------------------------------
   logic force_off;
   assign force_off = mon_i.thermal_sd | mon_i.supply_ovp | supply_uvlo;

   generate
      for (gi = 0; gi < 2; gi++) begin : g_pin
         logic [NSRC-1:0]            bad;
         logic                       all_good;
         logic [pgia_pkg::CNT_W-1:0] dcnt_r;
         logic                       gated;
         logic                       lvl;
         assign gated = mode_r[gi];
         // Selected, effective source that is out of tolerance
         always_comb begin
            bad = pgcfg_r[gi][pgia_pkg::PG_SEL +: NSRC] & eff & ~valid;
            for (int k = 0; k < pgia_pkg::NCONV; k++) begin
               if (gated && blank[k]) begin
                  bad[k] = 1'b0;
               end else if (!gated && pgcfg_r[gi][k] && eff[k] && mon_i.conv_moving[k]) begin
                  bad[k] = 1'b1;
               end
            end
         end
         assign all_good = ~|bad;

         // Assert delay counter; good only once it has run out
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               dcnt_r       <= '0;
               pg_good_r[gi] <= 1'b0;
            end else if (force_off || !all_good) begin
               dcnt_r        <= pgia_pkg::CNT_W'(RISE_DLY_CYC);
               pg_good_r[gi] <= 1'b0;
            end else if (pgcfg_r[gi][pgia_pkg::PG_DLY] && dcnt_r != '0) begin
               dcnt_r        <= dcnt_r - 1'b1;
               pg_good_r[gi] <= 1'b0;
            end else begin
               pg_good_r[gi] <= 1'b1;
            end
         end

         // Polarity and output type
         assign lvl = pg_good_r[gi] ~^ pgcfg_r[gi][pgia_pkg::PG_POL];
         if (gi == 0) begin : g_a
            assign power_good_out_a    = pgcfg_r[0][pgia_pkg::PG_OD] ? 1'b0 : lvl;
            assign power_good_out_a_oe = pgcfg_r[0][pgia_pkg::PG_OD] ? ~lvl : 1'b1;
         end else begin : g_b
            assign power_good_out_b    = pgcfg_r[1][pgia_pkg::PG_OD] ? 1'b0 : lvl;
            assign power_good_out_b_oe = pgcfg_r[1][pgia_pkg::PG_OD] ? ~lvl : 1'b1;
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Wishbone slave, one wait state, unmapped reads zero
   // ------------------------------------------------------------
   logic [31:0] rd_v;
   always_comb begin
      rd_v = 32'h0000_0000;
      case (wb_adr_i)
         pgia_pkg::OFS_FLAG:   rd_v[FW-1:0] = flag_r;
         pgia_pkg::OFS_MASK:   rd_v = mask_r;
         pgia_pkg::OFS_STATUS: begin
            rd_v[NSRC-1:0]           = valid;
            rd_v[pgia_pkg::ST_SYNC]  = mon_i.sync_present;
            rd_v[pgia_pkg::ST_PGA]   = pg_good_r[0];
            rd_v[pgia_pkg::ST_PGA+1] = pg_good_r[1];
         end
         pgia_pkg::OFS_CTRL:   rd_v[8:0] = ctrl_r;
         pgia_pkg::OFS_PGCFG: begin
            rd_v[10:0]  = pgcfg_r[0];
            rd_v[26:16] = pgcfg_r[1];
            rd_v[pgia_pkg::PG_MODE] = mode_r[0];
            rd_v[pgia_pkg::PG_MODE + pgia_pkg::PG_STRIDE] = mode_r[1];
         end
         default: rd_v = 32'h0000_0000;
      endcase
   end

   // Ack for one cycle; read data held until the next read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= rd_v;
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // Delay counter of pin a above one
   logic dcnt_r_a_nz;
   assign dcnt_r_a_nz = (g_pin[0].dcnt_r > pgia_pkg::CNT_W'(1));

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_irq_follows_pend: assert property (irq_any && !supply_uvlo |=> !host_irq_n)
      else $error("irq pin not low while pending");
   a_irq_release: assert property (!irq_any && !supply_uvlo |=> host_irq_n)
      else $error("irq pin low with nothing pending");
   a_boost_group_set: assert property (fall_ev[pgia_pkg::SRC_BOOST] && !supply_uvlo
      |=> flag_r[pgia_pkg::SRC_BOOST] && flag_r[pgia_pkg::FLG_BOOSTG])
      else $error("boost event lost");
   a_diag_group_set: assert property ((rise_ev[pgia_pkg::SRC_RAILA] ||
      fall_ev[pgia_pkg::SRC_RAILB] || rise_ev[pgia_pkg::SRC_SUPPLY]) && !supply_uvlo
      |=> flag_r[pgia_pkg::FLG_DIAGG])
      else $error("diagnostic group flag not set");
   a_meas_flag_set: assert property (mon_i.meas_done && !supply_uvlo
      |=> flag_r[pgia_pkg::FLG_MEAS])
      else $error("measurement flag not set");
   a_uvlo_release_flag: assert property ($fell(supply_uvlo) |=> flag_r[pgia_pkg::FLG_RREG])
      else $error("register reset flag missing after undervoltage");
   a_w1c_clears: assert property (wr_req && wb_adr_i == pgia_pkg::OFS_FLAG && wb_sel_i[0] &&
      wb_dat_i[0] && !set_v[0] && !supply_uvlo |=> !flag_r[0])
      else $error("write one did not clear flag");
   a_force_off_pins: assert property (mon_i.thermal_sd || mon_i.supply_ovp
      |=> pg_good_r == 2'b00)
      else $error("power good not forced off");
   a_delay_hold_off: assert property (pgcfg_r[0][pgia_pkg::PG_DLY] && !pg_good_r[0] &&
      dcnt_r_a_nz |=> !pg_good_r[0])
      else $error("power good asserted before delay");
   a_disabled_quiet: assert property (!eff[pgia_pkg::SRC_BOOST]
      |-> !rise_ev[pgia_pkg::SRC_BOOST] && !fall_ev[pgia_pkg::SRC_BOOST])
      else $error("disabled converter raised event");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   c_boost_event: cover property (rise_ev[pgia_pkg::SRC_BOOST] ##1 !host_irq_n);
   c_flag_cleared: cover property (flag_r[0] ##1 !flag_r[0]);
   c_pin_delayed: cover property (pgcfg_r[0][pgia_pkg::PG_DLY] ##0 $rose(pg_good_r[0]));
   c_sync_missing: cover property ($rose(ctrl_r[pgia_pkg::CTL_CLKDET]) && !mon_i.sync_present);
endmodule : pgia_top
`default_nettype wire

/* hdl/pgia_pkg.sv */
package pgia_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_FLAG   = 8'h00;
   localparam logic [7:0] OFS_MASK   = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_CTRL   = 8'h0c;
   localparam logic [7:0] OFS_PGCFG  = 8'h10;

   // ------------------------------------------------------------
   // Monitored sources and field positions
   // ------------------------------------------------------------
   localparam int NSRC      = 7;  // buck a, buck b, boost, supply, rail a, rail b, warn
   localparam int NCONV     = 3;  // Sources 0..2 are converters
   localparam int SRC_BUCKA = 0;
   localparam int SRC_BUCKB = 1;
   localparam int SRC_BOOST = 2;
   localparam int SRC_SUPPLY = 3;
   localparam int SRC_RAILA = 4;
   localparam int SRC_RAILB = 5;
   localparam int SRC_TWARN = 6;
   localparam int FLG_SYNC  = 7;
   localparam int FLG_MEAS  = 8;
   localparam int FLG_RREG  = 9;
   localparam int FLG_BUCKG = 10;
   localparam int FLG_BOOSTG = 11;
   localparam int FLG_DIAGG = 12;
   localparam int FLAG_W    = 13;
   localparam int MSK_FALL  = 8;   // Fall masks at [14:8], rise masks at [6:0]
   localparam int MSK_SYNC  = 16;
   localparam int MSK_MEAS  = 17;
   localparam int MSK_RREG  = 18;
   localparam int ST_SYNC   = 7;
   localparam int ST_PGA    = 8;
   localparam int CTL_OVCHK = 7;   // Monitor enables at [6:0]
   localparam int CTL_CLKDET = 8;
   localparam int PG_SEL    = 0;   // Per pin: select [6:0]
   localparam int PG_POL    = 8;
   localparam int PG_OD     = 9;
   localparam int PG_DLY    = 10;
   localparam int PG_MODE   = 11;  // Read only, from one-time config
   localparam int PG_STRIDE = 16;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [FLAG_W-1:0] FLAG_RST = 13'h0200;  // Register-reset flag set
   localparam logic [31:0]       MASK_RST = 32'h0000_0000;
   localparam logic [8:0]        CTRL_RST = 9'h040;    // Thermal warning monitored
   localparam logic [10:0]       PGCFG_RST = 11'h000;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ        = 50;
   localparam int GATE_WINDOW_US = 800;
   localparam int RISE_DELAY_MS  = 11;
   localparam int GATE_CYC       = GATE_WINDOW_US * CLK_MHZ;
   localparam int RISE_DLY_CYC   = RISE_DELAY_MS * 1000 * CLK_MHZ;
   localparam int CNT_W          = 20;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NSRC-2:0]  uv_ok;        // Above undervoltage, sources 0..5
      logic [NSRC-2:0]  ov_ok;        // Below overvoltage, sources 0..5
      logic [NCONV-1:0] conv_on;      // Converter enabled
      logic [NCONV-1:0] conv_moving;  // Converter ramping between targets
      logic             twarn;        // Thermal warning active
      logic             sync_present; // External clock seen
      logic             meas_done;    // Load current measurement done pulse
      logic             thermal_sd;
      logic             supply_ovp;
   } pgia_mon_s;

   typedef struct packed {
      logic [1:0] gated_mode;  // Per pin, 1 = gated, 0 = continuous
      logic [1:0] polarity;    // Per pin, 1 = active high
   } pgia_otp_s;
endpackage : pgia_pkg

/* testbench/pgia_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host board side of both good pins
module pgia_host (
   input  wire logic       pin_a,
   input  wire logic       oe_a,
   input  wire logic       pin_b,
   input  wire logic       oe_b,
   output logic      [1:0] pad
);
   // Released pad floats to the pull-up level
   assign pad = {oe_b ? pin_b : 1'b1, oe_a ? pin_a : 1'b1};
endmodule : pgia_host
`default_nettype wire

/* testbench/test_power_good_interrupt_aggregator.sv */
`timescale 1ns/1ps
`default_nettype none
module test_power_good_interrupt_aggregator;
   logic                clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic                uvlo = 1'b0, rev = 1'b0, ack, irq_n, pa, oa, pb, ob;
   logic [7:0]          adr = 8'h00;
   logic [31:0]         dw = 32'h0, dr, e;
   logic [1:0]          pad;
   pgia_pkg::pgia_mon_s mon;
   pgia_pkg::pgia_otp_s otp;
   int                  err_total = 0, tests_run = 0, g;
   logic [31:0]         q[$];
   // Clock and design
   always #10 clk = ~clk;
   pgia_top #(.GATE_CYC(20), .RISE_DLY_CYC(50)) uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw),
      .wb_dat_o(dr), .wb_ack_o(ack), .mon_i(mon), .otp_i(otp),
      .supply_uvlo(uvlo), .reset_event(rev), .host_irq_n(irq_n), .power_good_out_a(pa),
      .power_good_out_a_oe(oa), .power_good_out_b(pb), .power_good_out_b_oe(ob));
   pgia_host host (.pin_a(pa), .oe_a(oa), .pin_b(pb), .oe_b(ob), .pad(pad));
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // Read data checked against oldest note at ack
   always @(posedge clk) if (ack === 1'b1 && we === 1'b0 && q.size() > 0) cmp(dr, q.pop_front());
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dw  <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      q.push_back(x);
      bus(1'b0, a, 32'h0);
   endtask : rd
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim
   // Watchdog
   initial begin
      #200000;
      err_total++;
      end_sim();
   end
   // Main sequence
   initial begin
      mon = '0;
      mon.uv_ok = '1;
      mon.ov_ok = '1;
      mon.conv_on = '1;
      mon.sync_present = 1'b1;
      otp = 4'h3;
      void'($urandom(94796));
      wt(5);
      rst <= 1'b0;
      wt(3);
      cmp(irq_n, 32'h0);
      rd(pgia_pkg::OFS_FLAG, 32'h200);
      rd(pgia_pkg::OFS_CTRL, 32'h40);
      bus(1'b1, pgia_pkg::OFS_FLAG, 32'h200);
      rd(pgia_pkg::OFS_FLAG, 32'h0);
      cmp(irq_n, 32'h1);
      e = $urandom & 32'h7_7f7f;
      bus(1'b1, pgia_pkg::OFS_MASK, e);
      rd(pgia_pkg::OFS_MASK, e);
      bus(1'b1, pgia_pkg::OFS_MASK, 32'h0);
      bus(1'b1, pgia_pkg::OFS_CTRL, 32'h7f);
      bus(1'b1, pgia_pkg::OFS_FLAG, 32'h1fff);
      for (int s = 2; s < 6; s++) begin
         g = (s == 2) ? 11 : 12;
         for (int v = 0; v < 2; v++) begin
            mon.uv_ok[s] <= v[0];
            wt(3);
            e = (32'h1 << s) | (32'h1 << g);
            rd(pgia_pkg::OFS_FLAG, e);
            cmp(irq_n, 32'h0);
            bus(1'b1, pgia_pkg::OFS_FLAG, e);
            rd(pgia_pkg::OFS_FLAG, 32'h0);
         end
      end
      mon.ov_ok[4] <= 1'b0;
      mon.conv_on[2] <= 1'b0;
      wt(2);
      mon.uv_ok[2] <= 1'b0;
      wt(3);
      rd(pgia_pkg::OFS_FLAG, 32'h0);
      bus(1'b1, pgia_pkg::OFS_MASK, 32'h7_7f7f);
      mon.meas_done <= 1'b1;
      @(posedge clk);
      mon.meas_done <= 1'b0;
      wt(3);
      rd(pgia_pkg::OFS_FLAG, 32'h100);
      cmp(irq_n, 32'h1);
      bus(1'b1, pgia_pkg::OFS_MASK, 32'h0);
      wt(2);
      cmp(irq_n, 32'h0);
      bus(1'b1, pgia_pkg::OFS_PGCFG, 32'h0308_0108);
      wt(3);
      cmp({oa, ob, pa, pb, pad}, 32'h2b);
      mon.uv_ok[3] <= 1'b0;
      wt(3);
      cmp({oa, ob, pa, pb, pad}, 32'h30);
      mon.uv_ok[3] <= 1'b1;
      mon.thermal_sd <= 1'b1;
      wt(3);
      cmp(pad, 32'h0);
      bus(1'b1, pgia_pkg::OFS_PGCFG, 32'h0308_0508);
      mon.thermal_sd <= 1'b0;
      mon.uv_ok[3] <= 1'b0;
      wt(3);
      mon.uv_ok[3] <= 1'b1;
      wt(40);
      cmp(pad, 32'h2);
      wt(14);
      cmp(pad, 32'h3);
      uvlo <= 1'b1;
      wt(3);
      cmp(irq_n, 32'h1);
      uvlo <= 1'b0;
      wt(3);
      rd(pgia_pkg::OFS_FLAG, 32'h200);
      rd(pgia_pkg::OFS_CTRL, 32'h40);
      bus(1'b1, pgia_pkg::OFS_FLAG, 32'h1fff);
      rev <= 1'b1;
      @(posedge clk);
      rev <= 1'b0;
      wt(3);
      rd(pgia_pkg::OFS_FLAG, 32'h200);
      bus(1'b1, pgia_pkg::OFS_CTRL, 32'h140);
      bus(1'b1, pgia_pkg::OFS_FLAG, 32'h1fff);
      mon.sync_present <= 1'b0;
      wt(3);
      rd(pgia_pkg::OFS_FLAG, 32'h80);
      // Detector switched on with no clock, live status, window bit
      bus(1'b1, pgia_pkg::OFS_CTRL, 32'h40);
      bus(1'b1, pgia_pkg::OFS_FLAG, 32'h1fff);
      bus(1'b1, pgia_pkg::OFS_CTRL, 32'h140);
      wt(2);
      rd(pgia_pkg::OFS_FLAG, 32'h80);
      rd(pgia_pkg::OFS_STATUS, 32'h37b);
      bus(1'b1, pgia_pkg::OFS_CTRL, 32'h1c0);
      rd(pgia_pkg::OFS_STATUS, 32'h36b);
      // Pin a gated, pin b continuous, both watch the boost
      otp <= 4'h7;
      rev <= 1'b1;
      @(posedge clk);
      rev <= 1'b0;
      wt(3);
      bus(1'b1, pgia_pkg::OFS_CTRL, 32'h44);
      bus(1'b1, pgia_pkg::OFS_PGCFG, 32'h0104_0104);
      mon.conv_on[2] <= 1'b1;
      wt(3);
      cmp(pad, 32'h1);
      wt(25);
      cmp(pad, 32'h0);
      mon.uv_ok[2] <= 1'b1;
      wt(3);
      cmp(pad, 32'h3);
      mon.conv_moving[2] <= 1'b1;
      wt(3);
      cmp(pad, 32'h1);
      mon.conv_moving[2] <= 1'b0;
      mon.supply_ovp <= 1'b1;
      wt(3);
      cmp(pad, 32'h0);
      mon.supply_ovp <= 1'b0;
      rd(8'hfc, 32'h0);
      end_sim();
   end
endmodule : test_power_good_interrupt_aggregator
`default_nettype wire
